//--- inc/dpram_pkg.sv
// package for the dual-port block RAM output stage and width configuration
// assumes one clock (pclk) for both RAM ports and the APB slave
package dpram_pkg;

  // APB register byte offsets
  localparam logic [7:0] DPRAM_CTRL_OFFSET = 8'h00;
  localparam logic [7:0] DPRAM_RV_A_LO_OFFSET = 8'h04;
  localparam logic [7:0] DPRAM_RV_A_HI_OFFSET = 8'h08;
  localparam logic [7:0] DPRAM_RV_B_LO_OFFSET = 8'h0c;
  localparam logic [7:0] DPRAM_RV_B_HI_OFFSET = 8'h10;
  localparam logic [7:0] DPRAM_STATUS_OFFSET = 8'h14;

  // control register field positions
  localparam int DPRAM_CTRL_MODE_A_POS = 0;
  localparam int DPRAM_CTRL_MODE_B_POS = 2;
  localparam int DPRAM_CTRL_OUT_REG_A_POS = 4;
  localparam int DPRAM_CTRL_OUT_REG_B_POS = 5;
  localparam int DPRAM_CTRL_PREC_A_POS = 6;
  localparam int DPRAM_CTRL_PREC_B_POS = 7;
  localparam int DPRAM_CTRL_ADDR_LATCH_A_POS = 8;
  localparam int DPRAM_CTRL_ADDR_LATCH_B_POS = 9;
  localparam int DPRAM_CTRL_BITS = 10;
  localparam logic [9:0] DPRAM_CTRL_RESET = 10'h000;
  localparam logic [35:0] DPRAM_RV_RESET = 36'h0_0000_0000;

  // status register field positions
  localparam int DPRAM_STATUS_ADDR_A_POS = 0;
  localparam int DPRAM_STATUS_ADDR_B_POS = 16;

  localparam int DPRAM_DATA_BITS = 32;
  localparam int DPRAM_PARITY_BITS = 4;
  localparam int DPRAM_HALF_MAX = 36;
  localparam int DPRAM_ADDR_MAX = 15;

  typedef enum logic [1:0] {
    DPRAM_NEW_DATA_OUTPUT = 2'b00,
    DPRAM_OLD_DATA_OUTPUT = 2'b01,
    DPRAM_HOLD_OUTPUT = 2'b10
  } dpram_write_mode_type;

  typedef struct packed {
    logic [DPRAM_CTRL_BITS-1:0] ctrl;
    logic [35:0] rv_a;
    logic [35:0] rv_b;
    logic [14:0] addr_a;
    logic [14:0] addr_b;
    logic [35:0] lat_a;
    logic [35:0] lat_b;
    logic [35:0] reg_a;
    logic [35:0] reg_b;
    logic [31:0] prdata;
  } dpram_state_type;

endpackage

//--- design/dpram_core.sv
// dual-port block RAM: two user ports, output latch/register stage, APB config
// assumes both ports and APB share pclk; user inputs are synchronous to pclk
`timescale 1ns/1ps

// How it works
// [R1] latch or register reset loads the port output with its reset value
// [R2] reset value goes to output register if used, else to the latch
// [R3] port width 9/18/36 puts the top bits on parity, the rest on data
// [R4] simple dual-port value splits into two halves, each {parity, data}
// [R5] output register option adds one cycle of read latency
// [R6] widths 0,1,2,4,9,18,36; 72 only large variant simple dual-port; the code refuses 36-bit true dual-port ports on the small variant
// [R7] each port selects new-data, old-data or hold output on write
// [R8] each output register has its own enable and synchronous reset
// [R9] user sets read and write widths to match the chosen use
// [R10] simple dual-port data port at most 36 small, 72 large; the code accepts only exactly 36 small, 72 large
// [R11] user zero-extends narrow data and parity inputs
// [R12] data outputs 32 bits, parity 4 bits, low bits valid
// [R13] address is 14 bits small variant, 15 bits large variant
// [R14] 72-bit simple dual-port uses all eight port B enables
// [R15] 36-bit mode uses four enables per port
// [R16] 18-bit mode uses two enables per port, one per byte
// [R17] 9-bit or narrower uses only enable bit 0
// [R18] 36-bit simple dual-port on small variant uses port B enables [3:0]
// [R19] reset precedence loads the reset value into the register always; enable precedence needs enable
// [R20] address latching with hold enable low reuses the previous address
// [R21] after reset each output holds its configured initial value
// [R22] write modes show new data, old data, or leave output unchanged
module dpram_core
  import dpram_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1,
  parameter bit SIMPLE_DUAL_PORT = 1'b0,
  parameter int WIDTH_A = 36,
  parameter int WIDTH_B = 36,
  parameter int ADDR_W = LARGE_VARIANT ? 15 : 14,
  parameter logic [35:0] PORT_A_INIT_VALUE = 36'h0_0000_0000,
  parameter logic [35:0] PORT_B_INIT_VALUE = 36'h0_0000_0000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic port_a_enable,
  input wire logic [3:0] port_a_byte_write_enables,
  input wire logic [ADDR_W-1:0] port_a_address,
  input wire logic port_a_address_hold_enable,
  input wire logic [31:0] port_a_write_data,
  input wire logic [3:0] port_a_write_parity_in,
  input wire logic port_a_output_latch_reset,
  input wire logic port_a_output_register_reset,
  input wire logic port_a_output_register_clock_enable,
  output logic [31:0] port_a_read_data,
  output logic [3:0] port_a_read_parity_out,
  input wire logic port_b_enable,
  input wire logic [7:0] port_b_byte_write_enables,
  input wire logic [ADDR_W-1:0] port_b_address,
  input wire logic port_b_address_hold_enable,
  input wire logic [31:0] port_b_write_data,
  input wire logic [3:0] port_b_write_parity_in,
  input wire logic port_b_output_latch_reset,
  input wire logic port_b_output_register_reset,
  input wire logic port_b_output_register_clock_enable,
  output logic [31:0] port_b_read_data,
  output logic [3:0] port_b_read_parity_out
);

  function automatic int addr_lsb(input int w);
    case (w)
      2: return 1;
      4: return 2;
      9: return 3;
      18: return 4;
      36: return 5;
      72: return 6;
      default: return 0;
    endcase
  endfunction

  function automatic int data_bits(input int h);
    return (h < 9) ? h : h - h / 9;
  endfunction

  function automatic bit legal_width(input int w);
    return w == 0 || w == 1 || w == 2 || w == 4 || w == 9 || w == 18 || w == 36;
  endfunction

  localparam int MW_RAW = SIMPLE_DUAL_PORT ? WIDTH_B : ((WIDTH_A > WIDTH_B) ? WIDTH_A : WIDTH_B);
  localparam int MW = (MW_RAW == 0) ? 1 : MW_RAW;
  localparam int H = SIMPLE_DUAL_PORT ? MW / 2 : MW;
  localparam int D = data_bits(H);
  localparam int NB = (H == 36) ? 4 : ((H == 18) ? 2 : 1);
  localparam int LSB = addr_lsb(MW);
  localparam int DEPTH = 1 << (ADDR_W - LSB);
  localparam int IW = ADDR_W - LSB;
  localparam logic [35:0] RST_A = SIMPLE_DUAL_PORT ? PORT_A_INIT_VALUE : PORT_A_INIT_VALUE;
  localparam dpram_state_type RESET_STATE = '{
    ctrl: DPRAM_CTRL_RESET,
    rv_a: DPRAM_RV_RESET,
    rv_b: DPRAM_RV_RESET,
    addr_a: 15'h0000,
    addr_b: 15'h0000,
    lat_a: RST_A,
    lat_b: PORT_B_INIT_VALUE,
    reg_a: RST_A,
    reg_b: PORT_B_INIT_VALUE,
    prdata: 32'h0000_0000
  };

  // elaboration-time refusal of shapes the storage cannot serve
  generate
    if (ADDR_W != (LARGE_VARIANT ? 15 : 14)) begin : bad_addr_w
      $error("address width does not match the variant"); // [R13]
    end
    if (SIMPLE_DUAL_PORT) begin : chk_sdp
      if (WIDTH_A != WIDTH_B || WIDTH_B != (LARGE_VARIANT ? 72 : 36)) begin : bad_sdp
        $error("simple dual-port width must be 72 large or 36 small"); // [R10]
      end
    end else begin : chk_tdp
      if (!legal_width(WIDTH_A) || !legal_width(WIDTH_B)) begin : bad_w
        $error("port width must be 0,1,2,4,9,18 or 36"); // [R6]
      end
      if (WIDTH_A != WIDTH_B && WIDTH_A != 0 && WIDTH_B != 0) begin : bad_mix
        $error("used ports must share one width"); // [R9]
      end
      if (!LARGE_VARIANT && MW > 18) begin : bad_small
        $error("36-bit ports need the large variant"); // [R6]
      end
    end
  endgenerate

  function automatic logic [35:0] pack_half(input logic [31:0] data, input logic [3:0] par);
    logic [35:0] v;
    v = '0;
    for (int i = 0; i < H; i++) begin
      v[i] = (i < D) ? data[i] : par[i-D]; // [R3] [R4]
    end
    return v;
  endfunction

  function automatic logic [35:0] byte_mask(input logic [3:0] we);
    logic [35:0] m;
    m = '0;
    for (int i = 0; i < H; i++) begin
      if (H < 9) begin
        m[i] = we[0]; // [R17]
      end else if (i < D) begin
        m[i] = we[i/8]; // [R15] [R16]
      end else begin
        m[i] = we[i-D];
      end
    end
    return m;
  endfunction

  function automatic logic [MW-1:0] merge(input logic [MW-1:0] old, input logic [MW-1:0] nw,
                                          input logic [MW-1:0] m);
    return (old & ~m) | (nw & m);
  endfunction

  logic [MW-1:0] mem [DEPTH];
  dpram_state_type s_q;
  dpram_state_type s_d;
  logic [ADDR_W-1:0] eff_a;
  logic [ADDR_W-1:0] eff_b;
  logic [IW-1:0] idx_a;
  logic [IW-1:0] idx_b;
  logic [MW-1:0] old_a;
  logic [MW-1:0] old_b;
  logic [MW-1:0] word_a;
  logic [MW-1:0] word_b;
  logic wr_a;
  logic wr_b;
  logic [35:0] out_a;
  logic [35:0] out_b;
  logic access;
  logic mapped;

  always_comb begin
    logic [1:0] mode_a;
    logic [1:0] mode_b;
    logic [MW-1:0] mask_a;
    logic [MW-1:0] mask_b;
    logic [MW-1:0] nw_a;
    logic [MW-1:0] nw_b;
    mask_a = '0;
    mask_b = '0;
    nw_a = '0;
    nw_b = '0;
    mode_a = s_q.ctrl[DPRAM_CTRL_MODE_A_POS +: 2];
    mode_b = s_q.ctrl[DPRAM_CTRL_MODE_B_POS +: 2];
    s_d = s_q;
    // held address stands in while the hold enable is low
    eff_a = (s_q.ctrl[DPRAM_CTRL_ADDR_LATCH_A_POS] && !port_a_address_hold_enable)
      ? s_q.addr_a[ADDR_W-1:0] : port_a_address; // [R20]
    eff_b = (s_q.ctrl[DPRAM_CTRL_ADDR_LATCH_B_POS] && !port_b_address_hold_enable)
      ? s_q.addr_b[ADDR_W-1:0] : port_b_address; // [R20]
    s_d.addr_a = 15'(eff_a);
    s_d.addr_b = 15'(eff_b);
    idx_a = eff_a[ADDR_W-1:LSB];
    idx_b = eff_b[ADDR_W-1:LSB];
    old_a = mem[idx_a];
    old_b = mem[idx_b];
    if (SIMPLE_DUAL_PORT) begin
      // port B writes both halves; port A enables and width are ignored
      // halves sit side by side, so the high half starts at bit H: bit 36 on the large variant, bit 18 on the small one
      mask_a = MW'((72'(byte_mask(4'(port_b_byte_write_enables >> NB))) << H)
        | 72'(byte_mask(port_b_byte_write_enables[3:0]))); // [R14] [R18]
      nw_a = MW'((72'(pack_half(port_b_write_data, port_b_write_parity_in)) << H)
        | 72'(pack_half(port_a_write_data, port_a_write_parity_in))); // [R4]
      wr_a = 1'b0;
      wr_b = port_b_enable && (|port_b_byte_write_enables);
      word_a = '0;
      word_b = merge(old_b, nw_a, mask_a);
    end else begin
      mask_a = MW'(byte_mask(port_a_byte_write_enables)); // [R15] [R16] [R17]
      mask_b = MW'(byte_mask(port_b_byte_write_enables[3:0])); // [R15] [R16] [R17]
      nw_a = MW'(pack_half(port_a_write_data, port_a_write_parity_in));
      nw_b = MW'(pack_half(port_b_write_data, port_b_write_parity_in));
      wr_a = WIDTH_A != 0 && port_a_enable && (|port_a_byte_write_enables);
      wr_b = WIDTH_B != 0 && port_b_enable && (|port_b_byte_write_enables[3:0]);
      word_a = merge(old_a, nw_a, mask_a);
      word_b = merge(old_b, nw_b, mask_b);
    end

    // output latch stage
    if (SIMPLE_DUAL_PORT) begin
      if (port_a_enable) begin
        s_d.lat_a = port_a_output_latch_reset ? s_q.rv_a : 36'(old_a[H-1:0]); // [R1]
        s_d.lat_b = port_a_output_latch_reset ? s_q.rv_b : 36'(old_a >> H); // [R1] [R4]
      end
    end else begin
      if (port_a_enable && WIDTH_A != 0) begin
        if (port_a_output_latch_reset) begin
          s_d.lat_a = s_q.rv_a; // [R1] [R2]
        end else if (!wr_a || mode_a == DPRAM_OLD_DATA_OUTPUT) begin
          s_d.lat_a = 36'(old_a); // [R7] [R22]
        end else if (mode_a == DPRAM_NEW_DATA_OUTPUT) begin
          s_d.lat_a = 36'(word_a); // [R7] [R22]
        end
      end
      if (port_b_enable && WIDTH_B != 0) begin
        if (port_b_output_latch_reset) begin
          s_d.lat_b = s_q.rv_b; // [R1] [R2]
        end else if (!wr_b || mode_b == DPRAM_OLD_DATA_OUTPUT) begin
          s_d.lat_b = 36'(old_b); // [R7] [R22]
        end else if (mode_b == DPRAM_NEW_DATA_OUTPUT) begin
          s_d.lat_b = 36'(word_b); // [R7] [R22]
        end
      end
    end

    // optional output register stage, each port on its own enable
    if (port_a_output_register_reset && (!s_q.ctrl[DPRAM_CTRL_PREC_A_POS]
        || port_a_output_register_clock_enable)) begin
      s_d.reg_a = s_q.rv_a; // [R8] [R19] [R2]
    end else if (port_a_output_register_clock_enable) begin
      s_d.reg_a = s_q.lat_a; // [R8]
    end
    if (port_b_output_register_reset && (!s_q.ctrl[DPRAM_CTRL_PREC_B_POS]
        || port_b_output_register_clock_enable)) begin
      s_d.reg_b = s_q.rv_b; // [R8] [R19] [R2]
    end else if (port_b_output_register_clock_enable) begin
      s_d.reg_b = s_q.lat_b; // [R8]
    end

    // APB: read data captured in setup, writes land at the access edge
    if (psel && !penable) begin
      unique case (paddr)
        DPRAM_CTRL_OFFSET: s_d.prdata = 32'(s_q.ctrl);
        DPRAM_RV_A_LO_OFFSET: s_d.prdata = s_q.rv_a[31:0];
        DPRAM_RV_A_HI_OFFSET: s_d.prdata = 32'(s_q.rv_a[35:32]);
        DPRAM_RV_B_LO_OFFSET: s_d.prdata = s_q.rv_b[31:0];
        DPRAM_RV_B_HI_OFFSET: s_d.prdata = 32'(s_q.rv_b[35:32]);
        DPRAM_STATUS_OFFSET: begin
          s_d.prdata = '0;
          s_d.prdata[DPRAM_STATUS_ADDR_A_POS +: 15] = s_q.addr_a;
          s_d.prdata[DPRAM_STATUS_ADDR_B_POS +: 15] = s_q.addr_b;
        end
        default: s_d.prdata = 32'h0000_0000;
      endcase
    end
    if (access && pwrite && mapped) begin
      unique case (paddr)
        DPRAM_CTRL_OFFSET: s_d.ctrl = pwdata[DPRAM_CTRL_BITS-1:0];
        DPRAM_RV_A_LO_OFFSET: s_d.rv_a[31:0] = pwdata;
        DPRAM_RV_A_HI_OFFSET: s_d.rv_a[35:32] = pwdata[3:0];
        DPRAM_RV_B_LO_OFFSET: s_d.rv_b[31:0] = pwdata;
        DPRAM_RV_B_HI_OFFSET: s_d.rv_b[35:32] = pwdata[3:0];
        default: s_d.ctrl = s_q.ctrl;
      endcase
    end
  end

  assign access = psel && penable;
  assign mapped = paddr == DPRAM_CTRL_OFFSET || paddr == DPRAM_RV_A_LO_OFFSET
    || paddr == DPRAM_RV_A_HI_OFFSET || paddr == DPRAM_RV_B_LO_OFFSET
    || paddr == DPRAM_RV_B_HI_OFFSET || paddr == DPRAM_STATUS_OFFSET;
  assign pready = access;
  assign pslverr = access && !mapped;
  assign prdata = s_q.prdata;

  // output selection: register when the option is on, else the latch
  assign out_a = s_q.ctrl[DPRAM_CTRL_OUT_REG_A_POS] ? s_q.reg_a : s_q.lat_a; // [R5] [R2]
  assign out_b = s_q.ctrl[DPRAM_CTRL_OUT_REG_B_POS] ? s_q.reg_b : s_q.lat_b; // [R5] [R2]

  always_comb begin
    port_a_read_data = '0;
    port_a_read_parity_out = '0;
    port_b_read_data = '0;
    port_b_read_parity_out = '0;
    for (int i = 0; i < D; i++) begin
      port_a_read_data[i] = out_a[i]; // [R12] [R3]
      port_b_read_data[i] = out_b[i]; // [R12] [R3]
    end
    for (int j = 0; j < H - D; j++) begin
      port_a_read_parity_out[j] = out_a[D+j]; // [R12] [R3]
      port_b_read_parity_out[j] = out_b[D+j]; // [R12] [R3]
    end
  end

  // async reset loads the initial output values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= RESET_STATE; // [R21]
    end else begin
      s_q <= s_d;
    end
  end

  // array kept out of reset; a same-word collision lets port B win
  always_ff @(posedge pclk) begin
    if (wr_a) begin
      mem[idx_a] <= word_a;
    end
    if (wr_b) begin
      mem[idx_b] <= word_b;
    end
  end

endmodule

//--- bench/dpram_core_chk.sv
// assertions on port A of dpram_core, bound to the design
// assumes 36-bit ports; ctrl and the port A reset value are shadowed from APB writes
`timescale 1ns/1ps
module dpram_core_chk
  import dpram_pkg::*;
#(
  parameter logic [35:0] PORT_A_INIT_VALUE = 36'h0_0000_0000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic port_a_enable,
  input wire logic [3:0] port_a_byte_write_enables,
  input wire logic [31:0] port_a_write_data,
  input wire logic [3:0] port_a_write_parity_in,
  input wire logic port_a_output_latch_reset,
  input wire logic port_a_output_register_reset,
  input wire logic port_a_output_register_clock_enable,
  input wire logic [31:0] port_a_read_data,
  input wire logic [3:0] port_a_read_parity_out,
  input wire logic port_b_enable
);
  logic [9:0] ctrl_q;
  logic [35:0] rva_q;
  wire logic [35:0] qa = {port_a_read_parity_out, port_a_read_data};
  wire logic [35:0] wa = {port_a_write_parity_in, port_a_write_data};
  wire logic ra = ctrl_q[DPRAM_CTRL_OUT_REG_A_POS];
  wire logic prec = ctrl_q[DPRAM_CTRL_PREC_A_POS];
  wire logic apb_wr = psel && penable && pwrite;
  wire logic ce = port_a_output_register_clock_enable;
  wire logic rr = port_a_output_register_reset;
  // port b activity is excluded: a colliding port b write wins the word
  wire logic acc = port_a_enable && !port_a_output_latch_reset && !port_b_enable;
  wire logic wr_new = acc && port_a_byte_write_enables == 4'hf && ctrl_q[1:0] == 2'b00;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= DPRAM_CTRL_RESET;
      rva_q <= DPRAM_RV_RESET;
    end else if (apb_wr) begin
      if (paddr == DPRAM_CTRL_OFFSET) ctrl_q <= pwdata[9:0];
      if (paddr == DPRAM_RV_A_LO_OFFSET) rva_q[31:0] <= pwdata;
      if (paddr == DPRAM_RV_A_HI_OFFSET) rva_q[35:32] <= pwdata[3:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_INIT: assert property ($rose(presetn) |-> qa == PORT_A_INIT_VALUE)
    else $error("initial output value wrong");
  AST_LATCH_RST: assert property (port_a_enable && port_a_output_latch_reset
    && !ra |=> qa == rva_q)
    else $error("latch reset value wrong");
  AST_REG_RST: assert property (ra && rr && (!prec || ce) |=> qa == rva_q)
    else $error("register reset value wrong");
  AST_REG_HOLD: assert property (ra && !ce && (prec || !rr) && !apb_wr |=> $stable(qa))
    else $error("register changed without enable");
  AST_NEW_DATA: assert property (wr_new && !ra |=> qa == $past(wa))
    else $error("new data not shown");
  // hold mode only freezes the output on a write; a plain read still updates it
  AST_HOLD: assert property (acc && |port_a_byte_write_enables
    && ctrl_q[1:0] == 2'b10 && !ra |=> $stable(qa))
    else $error("hold mode output changed");
  AST_REG_LAT: assert property (wr_new && ra ##1 ce && !rr |=> qa == $past(wa, 2))
    else $error("register latency wrong");
  AST_READY: assert property (psel && penable |-> pready)
    else $error("apb ready missing");
  cover property (port_a_enable && port_a_output_latch_reset && !ra);
  cover property (ra && rr && prec && !ce);
  cover property (wr_new && ra);
endmodule
bind dpram_core dpram_core_chk #(.PORT_A_INIT_VALUE(PORT_A_INIT_VALUE)) i_dpram_core_chk (.*);

//--- bench/dpram_user_model.sv
// user logic model driving the RAM ports of dpram_core
// assumes pclk clocks both ports; port b control pins are tied by the bench
`timescale 1ns/1ps
module dpram_user_model (
  input wire logic pclk,
  output logic port_a_enable,
  output logic [3:0] port_a_byte_write_enables,
  output logic [14:0] port_a_address,
  output logic port_a_address_hold_enable,
  output logic [31:0] port_a_write_data,
  output logic [3:0] port_a_write_parity_in,
  output logic port_a_output_latch_reset,
  output logic port_a_output_register_reset,
  output logic port_a_output_register_clock_enable,
  output logic port_b_enable,
  output logic [7:0] port_b_byte_write_enables,
  output logic [14:0] port_b_address,
  output logic [31:0] port_b_write_data,
  output logic [3:0] port_b_write_parity_in
);
  initial begin
    {port_a_enable, port_a_byte_write_enables, port_a_address, port_a_write_data} = '0;
    {port_b_enable, port_b_byte_write_enables, port_b_address, port_b_write_data} = '0;
    {port_a_write_parity_in, port_b_write_parity_in} = 8'h00;
    {port_a_address_hold_enable, port_a_output_latch_reset, port_a_output_register_reset,
     port_a_output_register_clock_enable} = 4'b1001;
  end
  task automatic acc(input bit b, input logic [14:0] ad, input logic [7:0] we,
                     input logic [35:0] wd);
    @(posedge pclk);
    if (b) begin
      {port_b_enable, port_b_byte_write_enables, port_b_address} <= {1'b1, we, ad};
      {port_b_write_parity_in, port_b_write_data} <= wd;
    end else begin
      {port_a_enable, port_a_byte_write_enables, port_a_address} <= {1'b1, we[3:0], ad};
      {port_a_write_parity_in, port_a_write_data} <= wd;
    end
    @(posedge pclk);
    {port_a_enable, port_b_enable} <= 2'b00;
    // released data toggles so a stale word is never taken for a held one
    {port_a_write_data, port_b_write_data} <= ~{port_a_write_data, port_b_write_data};
  endtask
  task automatic ctl(input logic [3:0] c);
    @(posedge pclk);
    {port_a_address_hold_enable, port_a_output_latch_reset, port_a_output_register_reset,
     port_a_output_register_clock_enable} <= c;
  endtask
endmodule

//--- bench/testbench.sv
// self-checking bench for dpram_core: apb setup, write modes, byte lanes, output stage
// assumes 36-bit ports on the large variant
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module testbench;
  import dpram_pkg::*;
  localparam logic [35:0] IA = 36'h5_1234_5678;
  localparam logic [35:0] RV = 36'h9_dead_beef;
  localparam logic [35:0] W0 = 36'h1_1111_1111;
  localparam logic [35:0] WC = 36'hc_5555_aaaa;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd, port_a_write_data, port_b_write_data;
  logic [31:0] port_a_read_data, port_b_read_data;
  logic pready, pslverr, err, port_a_enable, port_b_enable, port_a_address_hold_enable;
  logic port_a_output_latch_reset, port_a_output_register_reset;
  logic port_a_output_register_clock_enable;
  logic [3:0] port_a_byte_write_enables, port_a_write_parity_in, port_b_write_parity_in;
  logic [3:0] port_a_read_parity_out, port_b_read_parity_out;
  logic [7:0] port_b_byte_write_enables;
  logic [14:0] port_a_address, port_b_address;
  logic port_b_address_hold_enable = 1'b1, port_b_output_latch_reset = 1'b0;
  logic port_b_output_register_reset = 1'b0, port_b_output_register_clock_enable = 1'b1;
  int errors = 0;
  int n_tests = 0;
  logic [35:0] wv [3] = '{W0, 36'h2_2222_2222, 36'h3_3333_3333};
  wire logic [35:0] qa = {port_a_read_parity_out, port_a_read_data};
  wire logic [35:0] qb = {port_b_read_parity_out, port_b_read_data};
  dpram_core #(.WIDTH_A(36), .WIDTH_B(36), .PORT_A_INIT_VALUE(IA)) i_dpram_core (.*);
  dpram_user_model i_dpram_user_model (.*);
  always #20 pclk = ~pclk;
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic acc(input bit b, input logic [14:0] ad, input logic [7:0] we,
                     input logic [35:0] wd);
    i_dpram_user_model.acc(b, ad, we, wd);
  endtask
  task automatic ctl_chk(input logic [3:0] c1, input logic [3:0] c2, input logic [35:0] e);
    i_dpram_user_model.ctl(c1);
    i_dpram_user_model.ctl(c2);
    @(negedge pclk);
    `CHK("output stage", e, qa)
  endtask
  task automatic report_and_stop();
    if (errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    `CHK("init a", IA, qa)
    apb(1'b1, DPRAM_RV_A_LO_OFFSET, RV[31:0]);
    apb(1'b1, DPRAM_RV_A_HI_OFFSET, {28'h0, RV[35:32]});
    apb(1'b0, DPRAM_RV_A_HI_OFFSET, 32'h0);
    `CHK("reset value hi", {28'h0, RV[35:32]}, rd)
    apb(1'b0, 8'h18, 32'h0);
    `CHK("unmapped", 33'h1_0000_0000, {err, rd})
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, DPRAM_CTRL_OFFSET, 32'(m));
      acc(1'b0, 15'h0060, 8'h0f, wv[m]);
      @(negedge pclk);
      `CHK("write mode", W0, qa)
    end
    acc(1'b1, 15'h0060, 8'h00, 36'h0);
    @(negedge pclk);
    `CHK("cross read", wv[2], qb)
    acc(1'b0, 15'h0060, 8'h05, 36'hf_aaaa_aaaa);
    acc(1'b1, 15'h0060, 8'hf0, 36'h0);
    acc(1'b1, 15'h0060, 8'h00, 36'h0);
    @(negedge pclk);
    `CHK("byte lanes", 36'h7_33aa_33aa, qb)
    acc(1'b1, 15'h0040, 8'h0f, 36'h8_8888_8888);
    @(negedge pclk);
    `CHK("port b write", 36'h8_8888_8888, qb)
    apb(1'b1, DPRAM_CTRL_OFFSET, 32'h0);
    // latch reset without a port enable leaves the last read word in place
    ctl_chk(4'b1001, 4'b1101, W0);
    acc(1'b0, 15'h0060, 8'h00, 36'h0);
    @(negedge pclk);
    `CHK("latch reset", RV, qa)
    apb(1'b1, DPRAM_CTRL_OFFSET, 32'h10);
    i_dpram_user_model.ctl(4'b1001);
    acc(1'b0, 15'h00a0, 8'h0f, WC);
    @(negedge pclk);
    `CHK("register stage", RV, qa)
    @(negedge pclk);
    `CHK("register stage", WC, qa)
    ctl_chk(4'b1010, 4'b1000, RV);
    apb(1'b1, DPRAM_CTRL_OFFSET, 32'h50);
    // the enable in the first step reloads the register from the latch
    ctl_chk(4'b1001, 4'b1010, WC);
    ctl_chk(4'b1000, 4'b1000, WC);
    ctl_chk(4'b1011, 4'b1001, RV);
    apb(1'b1, DPRAM_CTRL_OFFSET, 32'h100);
    acc(1'b0, 15'h0080, 8'h0f, 36'h6_0123_4567);
    i_dpram_user_model.ctl(4'b0001);
    acc(1'b0, 15'h0060, 8'h00, 36'h0);
    @(negedge pclk);
    `CHK("held address", 36'h6_0123_4567, qa)
    apb(1'b0, DPRAM_STATUS_OFFSET, 32'h0);
    `CHK("held address status", 32'h0040_0080, rd)
    report_and_stop();
  end
  initial begin
    repeat (3000) @(posedge pclk);
    errors++;
    report_and_stop();
  end
endmodule
